// >>> hdl/trip_pkg.sv
// Shared constants, types and helpers for the trip unit remote control block
package trip_pkg;

  // ==========================================================================
  // Clock and serial timing
  localparam int          CLK_HZ           = 125_000_000;
  localparam int          BAUD_A           = 9600;
  localparam int          BAUD_B           = 19200;
  localparam int          BAUD_C           = 38400;
  localparam int          BAUD_D           = 57600;
  localparam logic [15:0] DIV_A            = 16'(CLK_HZ / BAUD_A);
  localparam logic [15:0] DIV_B            = 16'(CLK_HZ / BAUD_B);
  localparam logic [15:0] DIV_C            = 16'(CLK_HZ / BAUD_C);
  localparam logic [15:0] DIV_D            = 16'(CLK_HZ / BAUD_D);
  localparam logic [1:0]  BAUD_SEL_A       = 2'h0;
  localparam logic [1:0]  BAUD_SEL_B       = 2'h1;
  localparam logic [1:0]  BAUD_SEL_C       = 2'h2;
  localparam logic [1:0]  BAUD_SEL_D       = 2'h3;
  localparam logic [1:0]  PAR_NONE         = 2'h0;
  localparam logic [1:0]  PAR_EVEN         = 2'h1;
  localparam logic [1:0]  PAR_ODD          = 2'h2;
  localparam logic [3:0]  CHAR_BITS        = 4'hb;
  localparam logic [5:0]  SILENCE_BITS     = 6'h27;

  // ==========================================================================
  // Reply delay
  localparam int          REPLY_SHORT_MS   = 5;
  localparam int          REPLY_LONG_MS    = 10;
  localparam int          REPLY_SHORT_CYC  = CLK_HZ / 1000 * REPLY_SHORT_MS;
  localparam int          REPLY_LONG_CYC   = CLK_HZ / 1000 * REPLY_LONG_MS;

  // ==========================================================================
  // Frame layout and protocol codes
  localparam logic [3:0]  FRAME_BYTES      = 4'h8;
  localparam logic [3:0]  ECHO_LEN         = 4'h6;
  localparam logic [3:0]  EXC_LEN          = 4'h3;
  localparam logic [7:0]  FC_WRITE_REG     = 8'h06;
  localparam logic [7:0]  FC_EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_DENIED       = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR     = 8'h02;
  localparam logic [7:0]  SLAVE_ADDR_MIN   = 8'h01;
  localparam logic [7:0]  SLAVE_ADDR_MAX   = 8'hf7;
  localparam logic [15:0] CRC_INIT         = 16'hffff;
  localparam logic [15:0] CRC_POLY         = 16'ha001;

  // ==========================================================================
  // Holding register map
  localparam logic [15:0] REG_FORCED_TRIP  = 16'h0000;
  localparam logic [15:0] REG_REMOTE_ARC   = 16'h0001;
  localparam logic [15:0] REG_TRIP_SEL     = 16'h0002;
  localparam logic [15:0] REG_CT_RATING    = 16'h0003;
  localparam logic [15:0] REG_SAVE         = 16'h0004;

  // ==========================================================================
  // Trip sources
  localparam int          NUM_SRC          = 5;
  localparam int          SRC_FAST_INST    = 0;
  localparam int          SRC_FAST_GF      = 1;
  localparam logic [4:0]  TRIP_SEL_RESET   = 5'h00;

  // Link states, Gray coded along idle, wait, send
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_SEND = 2'h3
  } link_state_e;

  // One byte step of the reflected CRC-16
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte

endpackage : trip_pkg

// >>> hdl/serial_byte_rx.sv
// Serial character receiver with pin synchroniser and parity check
module serial_byte_rx (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_rxd,
  input  wire logic        i_enable,
  input  wire logic [15:0] i_div,
  input  wire logic [1:0]  i_parity_sel,
  output logic [7:0]       o_byte,
  output logic             o_byte_valid,
  output logic             o_byte_err
);

  logic        rxd_meta_r;
  logic        rxd_r;
  logic        active_r;
  logic [15:0] cnt_r;
  logic [3:0]  bit_idx_r;
  logic        par_r;
  logic        par_en;
  logic        par_exp;

  assign par_en  = (i_parity_sel == trip_pkg::PAR_EVEN) || (i_parity_sel == trip_pkg::PAR_ODD);
  assign par_exp = (i_parity_sel == trip_pkg::PAR_ODD) ? ~^o_byte : ^o_byte;

  // ==========================================================================
  // Pin synchroniser
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rxd_meta_r <= 1'b1;
      rxd_r      <= 1'b1;
    end else begin
      rxd_meta_r <= i_rxd;
      rxd_r      <= rxd_meta_r;
    end
  end

  // ==========================================================================
  // Bit sampler, mid-bit after start edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_r     <= 1'b0;
      cnt_r        <= 16'h0000;
      bit_idx_r    <= 4'h0;
      par_r        <= 1'b0;
      o_byte       <= 8'h00;
      o_byte_valid <= 1'b0;
      o_byte_err   <= 1'b0;
    end else begin
      o_byte_valid <= 1'b0;
      if (!i_enable) begin
        active_r <= 1'b0;
      end else if (!active_r) begin
        if (!rxd_r) begin
          active_r  <= 1'b1;
          cnt_r     <= i_div >> 1;
          bit_idx_r <= 4'h0;
        end
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r     <= i_div - 16'h0001;
        bit_idx_r <= bit_idx_r + 4'h1;
        if (bit_idx_r == 4'h0) begin
          active_r <= ~rxd_r; // False start is dropped
        end else if (bit_idx_r <= 4'h8) begin
          o_byte <= {rxd_r, o_byte[7:1]};
        end else if (bit_idx_r == 4'h9 && par_en) begin
          par_r <= rxd_r;
        end else begin
          // Stop bit: report byte, flag framing or parity fault
          active_r     <= 1'b0;
          o_byte_valid <= 1'b1;
          o_byte_err   <= ~rxd_r | (par_en & (par_r != par_exp));
        end
      end
    end
  end

endmodule : serial_byte_rx

// >>> hdl/trip_unit_remote_control.sv
// Serial slave, remote permissives, arc reduction and segregated trip selection
//
// Function
// - Slave address 1 to 247, unique per pair
// - Reply waits at least 5 or 10 ms
// - Serial port idle unless comms enabled
// - Baud and parity selectable, match master
// - Remote forced trip needs local permissive
// - Network setting changes need settings permissive
// - CT rating never writable over network
// - Remote arc reduction on needs permissive
// - Arc mode on if local or remote
// - Arc mode enables both fast trip functions
// - Indication output follows arc mode
// - Per-source selection gates segregated trip relay
// - Save writes edited settings to memory
module trip_unit_remote_control #(
  parameter int REPLY_SHORT_CYCLES = trip_pkg::REPLY_SHORT_CYC,
  parameter int REPLY_LONG_CYCLES  = trip_pkg::REPLY_LONG_CYC
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  input  wire logic       I_RXD,
  input  wire logic       I_COMM_EN,
  input  wire logic [7:0] I_SLAVE_ADDR,
  input  wire logic [1:0] I_BAUD_SEL,
  input  wire logic [1:0] I_PARITY_SEL,
  input  wire logic       I_REPLY_DELAY_LONG,
  input  wire logic       I_FORCED_TRIP_PERMIT,
  input  wire logic       I_SETTINGS_PERMIT,
  input  wire logic       I_REMOTE_ARC_REDUCTION_PERMIT,
  input  wire logic       I_LOCAL_ARC_SWITCH,
  input  wire logic [4:0] I_TRIP_REQ,
  input  wire logic       I_LOCAL_SEL_WE,
  input  wire logic [4:0] I_LOCAL_SEL,
  input  wire logic       I_LOCAL_SAVE,
  output logic            O_TXD,
  output logic            O_TX_EN,
  output logic            O_FORCED_TRIP,
  output logic            O_ARC_ACTIVE,
  output logic            O_FAST_INSTANTANEOUS_TRIP_EN,
  output logic            O_FAST_GROUND_FAULT_TRIP_EN,
  output logic            O_SEGREGATED_TRIP_RELAY,
  output logic [4:0]      O_TRIP_SEL,
  output logic            O_NVM_WRITE,
  output logic [4:0]      O_NVM_DATA
);

  logic [15:0]           div;
  logic [15:0]           tick_cnt_r;
  logic                  bit_tick_r;
  logic [7:0]            rx_byte;
  logic                  rx_valid;
  logic                  rx_err;
  logic [5:0]            idle_bits_r;
  logic [7:0]            rx_buf_r [6];
  logic [3:0]            rx_cnt_r;
  logic [15:0]           rx_crc_r;
  logic                  rx_bad_r;
  logic                  frame_end;
  logic                  frame_ok;
  logic [15:0]           reg_addr;
  logic [15:0]           reg_val;
  logic                  accept;
  logic                  deny;
  trip_pkg::link_state_e state_r;
  logic [23:0]           delay_r;
  logic [7:0]            tx_buf_r [6];
  logic [3:0]            tx_len_r;
  logic [3:0]            tx_idx_r;
  logic [15:0]           tx_crc_r;
  logic [10:0]           tx_shift_r;
  logic [3:0]            tx_bits_r;
  logic                  tx_active_r;
  logic [7:0]            tx_byte;
  logic                  tx_par;
  logic                  arc_sw_meta_r;
  logic                  arc_sw_r;
  logic                  remote_arc_r;
  logic [4:0]            trip_sel_r;
  logic [4:0]            src_fire;

  // ==========================================================================
  // Bit period per baud selection
  always_comb begin
    unique case (I_BAUD_SEL)
      trip_pkg::BAUD_SEL_A: div = trip_pkg::DIV_A;
      trip_pkg::BAUD_SEL_B: div = trip_pkg::DIV_B;
      trip_pkg::BAUD_SEL_C: div = trip_pkg::DIV_C;
      trip_pkg::BAUD_SEL_D: div = trip_pkg::DIV_D;
    endcase
  end

  // Free-running bit-rate enable
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tick_cnt_r <= 16'h0000;
      bit_tick_r <= 1'b0;
    end else begin
      bit_tick_r <= (tick_cnt_r >= div - 16'h0001);
      tick_cnt_r <= (tick_cnt_r >= div - 16'h0001) ? 16'h0000 : tick_cnt_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Receiver
  serial_byte_rx u_rx (
    .i_clk        (I_CLK),
    .i_reset_n    (I_RESET_N),
    .i_rxd        (I_RXD),
    .i_enable     (I_COMM_EN),
    .i_div        (div),
    .i_parity_sel (I_PARITY_SEL),
    .o_byte       (rx_byte),
    .o_byte_valid (rx_valid),
    .o_byte_err   (rx_err)
  );

  // Line silence closes the frame
  assign frame_end = bit_tick_r && (idle_bits_r == trip_pkg::SILENCE_BITS - 6'h01)
                     && (rx_cnt_r != 4'h0);

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      idle_bits_r <= 6'h00;
    end else if (rx_valid) begin
      idle_bits_r <= 6'h00;
    end else if (bit_tick_r && idle_bits_r != trip_pkg::SILENCE_BITS) begin
      idle_bits_r <= idle_bits_r + 6'h01;
    end
  end

  // Frame capture, running check
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_cnt_r <= 4'h0;
      rx_crc_r <= trip_pkg::CRC_INIT;
      rx_bad_r <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        rx_buf_r[i] <= 8'h00;
      end
    end else if (!I_COMM_EN || frame_end || state_r != trip_pkg::ST_IDLE) begin
      rx_cnt_r <= 4'h0;
      rx_crc_r <= trip_pkg::CRC_INIT;
      rx_bad_r <= 1'b0;
    end else if (rx_valid) begin
      if (rx_cnt_r < 4'h6) begin
        rx_buf_r[rx_cnt_r[2:0]] <= rx_byte;
      end
      rx_cnt_r <= (rx_cnt_r > trip_pkg::FRAME_BYTES) ? rx_cnt_r : rx_cnt_r + 4'h1;
      rx_crc_r <= trip_pkg::crc16_byte(rx_crc_r, rx_byte);
      rx_bad_r <= rx_bad_r | rx_err;
    end
  end

  // ==========================================================================
  // Request decode and permissive gating
  assign reg_addr = {rx_buf_r[2], rx_buf_r[3]};
  assign reg_val  = {rx_buf_r[4], rx_buf_r[5]};
  assign frame_ok = frame_end && I_COMM_EN && state_r == trip_pkg::ST_IDLE
                    && rx_cnt_r == trip_pkg::FRAME_BYTES && rx_crc_r == 16'h0000
                    && !rx_bad_r && rx_buf_r[0] == I_SLAVE_ADDR
                    && I_SLAVE_ADDR >= trip_pkg::SLAVE_ADDR_MIN
                    && I_SLAVE_ADDR <= trip_pkg::SLAVE_ADDR_MAX
                    && rx_buf_r[1] == trip_pkg::FC_WRITE_REG;

  always_comb begin
    accept = 1'b0;
    deny   = 1'b0;
    unique case (reg_addr)
      trip_pkg::REG_FORCED_TRIP: begin
        accept = I_FORCED_TRIP_PERMIT;
        deny   = ~I_FORCED_TRIP_PERMIT;
      end
      trip_pkg::REG_REMOTE_ARC: begin
        accept = (reg_val == 16'h0000) || I_REMOTE_ARC_REDUCTION_PERMIT;
        deny   = (reg_val != 16'h0000) && !I_REMOTE_ARC_REDUCTION_PERMIT;
      end
      trip_pkg::REG_TRIP_SEL, trip_pkg::REG_SAVE: begin
        accept = I_SETTINGS_PERMIT;
        deny   = ~I_SETTINGS_PERMIT;
      end
      trip_pkg::REG_CT_RATING: deny = 1'b1;
      default: deny = 1'b0;
    endcase
  end

  // ==========================================================================
  // Reply sequencer: delay, then send with check
  assign tx_byte = (tx_idx_r < tx_len_r) ? tx_buf_r[tx_idx_r[2:0]]
                 : (tx_idx_r == tx_len_r) ? tx_crc_r[7:0] : tx_crc_r[15:8];
  assign tx_par  = (I_PARITY_SEL == trip_pkg::PAR_EVEN) ? ^tx_byte
                 : (I_PARITY_SEL == trip_pkg::PAR_ODD) ? ~^tx_byte : 1'b1;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r     <= trip_pkg::ST_IDLE;
      delay_r     <= 24'h00_0000;
      tx_len_r    <= 4'h0;
      tx_idx_r    <= 4'h0;
      tx_crc_r    <= trip_pkg::CRC_INIT;
      tx_shift_r  <= 11'h7ff;
      tx_bits_r   <= 4'h0;
      tx_active_r <= 1'b0;
      O_TXD       <= 1'b1;
      O_TX_EN     <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        tx_buf_r[i] <= 8'h00;
      end
    end else if (!I_COMM_EN) begin
      state_r     <= trip_pkg::ST_IDLE;
      tx_active_r <= 1'b0;
      O_TXD       <= 1'b1;
      O_TX_EN     <= 1'b0;
    end else begin
      unique case (state_r)
        trip_pkg::ST_IDLE: begin
          if (frame_ok) begin
            state_r <= trip_pkg::ST_WAIT;
            delay_r <= I_REPLY_DELAY_LONG ? 24'(REPLY_LONG_CYCLES - 1)
                                          : 24'(REPLY_SHORT_CYCLES - 1);
            if (accept) begin
              tx_len_r <= trip_pkg::ECHO_LEN;
              for (int i = 0; i < 6; i++) begin
                tx_buf_r[i] <= rx_buf_r[i];
              end
            end else begin
              tx_len_r    <= trip_pkg::EXC_LEN;
              tx_buf_r[0] <= rx_buf_r[0];
              tx_buf_r[1] <= rx_buf_r[1] | trip_pkg::FC_EXC_FLAG;
              tx_buf_r[2] <= deny ? trip_pkg::EXC_DENIED : trip_pkg::EXC_BAD_ADDR;
            end
          end
        end
        trip_pkg::ST_WAIT: begin
          if (delay_r == 24'h00_0000) begin
            state_r  <= trip_pkg::ST_SEND;
            tx_idx_r <= 4'h0;
            tx_crc_r <= trip_pkg::CRC_INIT;
            O_TX_EN  <= 1'b1;
          end else begin
            delay_r <= delay_r - 24'h00_0001;
          end
        end
        trip_pkg::ST_SEND: begin
          if (!tx_active_r) begin
            if (tx_idx_r == tx_len_r + 4'h2) begin
              state_r <= trip_pkg::ST_IDLE;
              O_TX_EN <= 1'b0;
            end else begin
              // Start, eight data bits, parity or stop, stop
              tx_shift_r  <= {1'b1, tx_par, tx_byte, 1'b0};
              tx_bits_r   <= trip_pkg::CHAR_BITS;
              tx_active_r <= 1'b1;
              tx_idx_r    <= tx_idx_r + 4'h1;
              if (tx_idx_r < tx_len_r) begin
                tx_crc_r <= trip_pkg::crc16_byte(tx_crc_r, tx_byte);
              end
            end
          end else if (bit_tick_r) begin
            if (tx_bits_r != 4'h0) begin
              O_TXD      <= tx_shift_r[0];
              tx_shift_r <= {1'b1, tx_shift_r[10:1]};
              tx_bits_r  <= tx_bits_r - 4'h1;
            end else begin
              tx_active_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Remote commands, settings and save
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FORCED_TRIP <= 1'b0;
      remote_arc_r  <= 1'b0;
      trip_sel_r    <= trip_pkg::TRIP_SEL_RESET;
      O_NVM_WRITE   <= 1'b0;
      O_NVM_DATA    <= trip_pkg::TRIP_SEL_RESET;
    end else begin
      O_FORCED_TRIP <= frame_ok && accept && reg_addr == trip_pkg::REG_FORCED_TRIP
                       && reg_val != 16'h0000;
      if (frame_ok && accept && reg_addr == trip_pkg::REG_REMOTE_ARC) begin
        remote_arc_r <= (reg_val != 16'h0000);
      end
      if (I_LOCAL_SEL_WE) begin
        trip_sel_r <= I_LOCAL_SEL;
      end else if (frame_ok && accept && reg_addr == trip_pkg::REG_TRIP_SEL) begin
        trip_sel_r <= reg_val[4:0];
      end
      O_NVM_WRITE <= I_LOCAL_SAVE || (frame_ok && accept && reg_addr == trip_pkg::REG_SAVE);
      if (I_LOCAL_SAVE || (frame_ok && accept && reg_addr == trip_pkg::REG_SAVE)) begin
        O_NVM_DATA <= trip_sel_r;
      end
    end
  end

  // ==========================================================================
  // Arc reduction mode and indication
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      arc_sw_meta_r                <= 1'b0;
      arc_sw_r                     <= 1'b0;
      O_ARC_ACTIVE                 <= 1'b0;
      O_FAST_INSTANTANEOUS_TRIP_EN <= 1'b0;
      O_FAST_GROUND_FAULT_TRIP_EN  <= 1'b0;
    end else begin
      arc_sw_meta_r                <= I_LOCAL_ARC_SWITCH;
      arc_sw_r                     <= arc_sw_meta_r;
      O_ARC_ACTIVE                 <= arc_sw_r | remote_arc_r;
      O_FAST_INSTANTANEOUS_TRIP_EN <= arc_sw_r | remote_arc_r;
      O_FAST_GROUND_FAULT_TRIP_EN  <= arc_sw_r | remote_arc_r;
    end
  end

  // ==========================================================================
  // Per-source relay gating
  for (genvar g = 0; g < trip_pkg::NUM_SRC; g++) begin : g_src
    if (g == trip_pkg::SRC_FAST_INST || g == trip_pkg::SRC_FAST_GF) begin : g_fast
      assign src_fire[g] = I_TRIP_REQ[g] & trip_sel_r[g] & O_ARC_ACTIVE;
    end else begin : g_plain
      assign src_fire[g] = I_TRIP_REQ[g] & trip_sel_r[g];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SEGREGATED_TRIP_RELAY <= 1'b0;
      O_TRIP_SEL              <= trip_pkg::TRIP_SEL_RESET;
    end else begin
      O_SEGREGATED_TRIP_RELAY <= |src_fire;
      O_TRIP_SEL              <= trip_sel_r;
    end
  end

endmodule : trip_unit_remote_control

// >>> dv/trip_unit_remote_control_asserts.sv
// Port checker, trip unit remote control
module trip_unit_remote_control_asserts #(
  parameter int REPLY_SHORT_CYCLES = 200,
  parameter int REPLY_LONG_CYCLES  = 400
) (
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  input wire logic       I_RXD,
  input wire logic       I_COMM_EN,
  input wire logic       I_REPLY_DELAY_LONG,
  input wire logic       I_FORCED_TRIP_PERMIT,
  input wire logic       I_LOCAL_ARC_SWITCH,
  input wire logic [4:0] I_TRIP_REQ,
  input wire logic       I_LOCAL_SEL_WE,
  input wire logic [4:0] I_LOCAL_SEL,
  input wire logic       I_LOCAL_SAVE,
  input wire logic       O_TXD,
  input wire logic       O_TX_EN,
  input wire logic       O_FORCED_TRIP,
  input wire logic       O_ARC_ACTIVE,
  input wire logic       O_FAST_INSTANTANEOUS_TRIP_EN,
  input wire logic       O_FAST_GROUND_FAULT_TRIP_EN,
  input wire logic       O_SEGREGATED_TRIP_RELAY,
  input wire logic [4:0] O_TRIP_SEL,
  input wire logic       O_NVM_WRITE
);
  timeunit 1ns;
  timeprecision 1ps;
  int quiet_r;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Line quiet counter, saturating
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) quiet_r <= 0;
    else if (!I_RXD) quiet_r <= 0;
    else if (quiet_r < 32'h0fff_ffff) quiet_r <= quiet_r + 1;
  end
  sequence s_switch_held;
    I_LOCAL_ARC_SWITCH [*5];
  endsequence
  sequence s_comm_off;
    !I_COMM_EN [*4];
  endsequence
  // ==========================================================================
  // Properties
  chk_arc_from_switch: assert property (s_switch_held |=> O_ARC_ACTIVE)
    else $error("arc off");
  chk_fast_trip_en: assert property (O_FAST_INSTANTANEOUS_TRIP_EN == O_ARC_ACTIVE && O_FAST_GROUND_FAULT_TRIP_EN == O_ARC_ACTIVE)
    else $error("fast en");
  chk_relay_slow_src: assert property (|($past(I_TRIP_REQ[4:2]) & O_TRIP_SEL[4:2]) |-> O_SEGREGATED_TRIP_RELAY)
    else $error("relay missed");
  chk_relay_has_cause: assert property (O_SEGREGATED_TRIP_RELAY |-> |($past(I_TRIP_REQ) & O_TRIP_SEL))
    else $error("relay uncaused");
  chk_sel_local_load: assert property (I_LOCAL_SEL_WE |-> ##2 O_TRIP_SEL == $past(I_LOCAL_SEL, 2))
    else $error("sel load");
  chk_port_off: assert property (s_comm_off |-> !O_TX_EN && O_TXD)
    else $error("port on");
  chk_forced_permit: assert property (O_FORCED_TRIP |-> $past(I_FORCED_TRIP_PERMIT) && $past(I_COMM_EN))
    else $error("forced ungated");
  chk_forced_pulse: assert property (O_FORCED_TRIP |=> !O_FORCED_TRIP)
    else $error("forced long");
  chk_local_save: assert property (I_LOCAL_SAVE |-> ##[1:2] O_NVM_WRITE)
    else $error("no save");
  chk_reply_delay: assert property ($rose(O_TX_EN) |-> quiet_r >= (I_REPLY_DELAY_LONG ? REPLY_LONG_CYCLES : REPLY_SHORT_CYCLES))
    else $error("reply early");
endmodule : trip_unit_remote_control_asserts

bind trip_unit_remote_control trip_unit_remote_control_asserts #(
  .REPLY_SHORT_CYCLES(REPLY_SHORT_CYCLES),
  .REPLY_LONG_CYCLES (REPLY_LONG_CYCLES)
) u_chk (.*);

// >>> dv/rtu_master_model.sv
// Serial master: sends requests, reads replies
module rtu_master_model #(
  parameter int BIT_CYC = 2170
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_tx_en,
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Biased bus idles high
  initial o_rxd = 1'b1;
  // Reflected CRC step
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction : crc_step
  // Start, data LSB first, even parity, stop
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] ch;
    ch = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_rxd = ch[i];
      repeat (BIT_CYC) @(posedge i_clk);
      #1;
    end
  endtask : send_byte
  // Write request, check low byte first
  task automatic send_frame(input logic [7:0] addr, input logic [15:0] ra, val);
    logic [7:0]  fr [8];
    logic [15:0] crc;
    fr = '{addr, 8'h06, ra[15:8], ra[7:0], val[15:8], val[7:0], 8'h00, 8'h00};
    crc = 16'hffff;
    for (int i = 0; i < 6; i++) crc = crc_step(crc, fr[i]);
    fr[6] = crc[7:0];
    fr[7] = crc[15:8];
    for (int i = 0; i < 8; i++) send_byte(fr[i]);
  endtask : send_frame
  // Read one reply byte
  task automatic get_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (!(i_tx_en === 1'b1 && i_txd === 1'b0) && n < 40 * BIT_CYC) begin
      @(posedge i_clk);
      n++;
    end
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = i_txd;
      repeat (BIT_CYC) @(posedge i_clk);
    end
    repeat (BIT_CYC) @(posedge i_clk);
  endtask : get_byte
endmodule : rtu_master_model

// >>> dv/tb.sv
// Self-checking bench, trip unit remote control
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT = 200;
  localparam int LONG  = 400;
  localparam int BIT   = int'(trip_pkg::DIV_D);
  localparam int LIMIT = 4_000_000;
  typedef struct packed {
    logic [7:0] addr; logic [15:0] ra; logic [15:0] val; logic [3:0] cfg; logic [7:0] fc; logic [7:0] ev;
  } frame_s;
  logic I_CLK = 1'b0, I_RESET_N, I_RXD, I_COMM_EN, I_REPLY_DELAY_LONG, I_FORCED_TRIP_PERMIT;
  logic I_SETTINGS_PERMIT, I_REMOTE_ARC_REDUCTION_PERMIT, I_LOCAL_ARC_SWITCH, I_LOCAL_SEL_WE;
  logic I_LOCAL_SAVE, O_TXD, O_TX_EN, O_FORCED_TRIP, O_ARC_ACTIVE, O_FAST_INSTANTANEOUS_TRIP_EN;
  logic O_FAST_GROUND_FAULT_TRIP_EN, O_SEGREGATED_TRIP_RELAY, O_NVM_WRITE, arc_exp;
  logic [7:0] I_SLAVE_ADDR, b, exp_q [$];
  logic [1:0] I_BAUD_SEL, I_PARITY_SEL;
  logic [4:0] I_TRIP_REQ, I_LOCAL_SEL, O_TRIP_SEL, O_NVM_DATA, sel;
  logic [31:0] r;
  int num_errors = 0, checks = 0, cyc = 0, seed = 66238, n, dly;
  frame_s tbl [9];
  trip_unit_remote_control #(.REPLY_SHORT_CYCLES(SHORT), .REPLY_LONG_CYCLES(LONG)) u_dut (.*);
  rtu_master_model #(.BIT_CYC(BIT)) u_master (.i_clk(I_CLK), .i_txd(O_TXD), .i_tx_en(O_TX_EN), .o_rxd(I_RXD));
  always #4 I_CLK = ~I_CLK;
  // ==========================================================================
  // Shared tasks
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      num_errors++;
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // Event scoreboard, timeout
  always @(posedge I_CLK) begin
    cyc++;
    if (I_RESET_N && (O_FORCED_TRIP === 1'b1 || O_NVM_WRITE === 1'b1)) begin
      checks++;
      if (exp_q.size() == 0 || exp_q.pop_front() !== {O_FORCED_TRIP, O_NVM_WRITE, 1'b0, O_NVM_DATA}) begin
        $display("unexpected at %0t: event", $time);
        num_errors++;
      end
    end
    if (cyc == LIMIT) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {I_RESET_N, I_COMM_EN, I_REPLY_DELAY_LONG, I_FORCED_TRIP_PERMIT} = 4'h0;
    {I_SETTINGS_PERMIT, I_REMOTE_ARC_REDUCTION_PERMIT, I_LOCAL_ARC_SWITCH} = 3'h0;
    {I_LOCAL_SEL_WE, I_LOCAL_SAVE, I_TRIP_REQ, I_LOCAL_SEL} = 12'h000;
    I_SLAVE_ADDR = 8'hf7;
    I_BAUD_SEL = 2'h3;
    I_PARITY_SEL = 2'h1;
    sel = 5'h00;
    tick(10);
    I_RESET_N = 1'b1;
    // Random local inputs
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      sel = r[4:0];
      I_LOCAL_SEL = sel;
      I_LOCAL_SEL_WE = 1'b1;
      I_LOCAL_ARC_SWITCH = r[5];
      I_TRIP_REQ = r[10:6];
      tick(1);
      I_LOCAL_SEL_WE = 1'b0;
      tick(6);
      check(8'(O_TRIP_SEL), 8'(sel), "selection");
      check(8'(O_ARC_ACTIVE), 8'(r[5]), "arc");
      check(8'(O_SEGREGATED_TRIP_RELAY), 8'(|(r[10:6] & sel & {3'h7, {2{r[5]}}})), "relay");
    end
    I_LOCAL_ARC_SWITCH = 1'b0;
    I_LOCAL_SAVE = 1'b1;
    exp_q.push_back({3'b010, sel});
    tick(1);
    I_LOCAL_SAVE = 1'b0;
    // cfg: comms, forced, arc, settings
    tbl = '{'{8'hf7, 16'h0000, 16'h0001, 4'hc, 8'h06, {3'b100, sel}},
            '{8'hf7, 16'h0000, 16'h0001, 4'hb, 8'h86, 8'h00},
            '{8'hf7, 16'h0001, 16'h0001, 4'hd, 8'h86, 8'h00}, '{8'hf7, 16'h0001, 16'h0001, 4'ha, 8'h06, 8'h00},
            '{8'hf7, 16'h0003, 16'h0010, 4'hf, 8'h86, 8'h00}, '{8'hf7, 16'h0002, 16'h0015, 4'hc, 8'h86, 8'h00},
            '{8'hf7, 16'h0004, 16'h0000, 4'h9, 8'h06, {3'b010, sel}},
            '{8'hf6, 16'h0000, 16'h0001, 4'hf, 8'h00, 8'h00}, '{8'hf7, 16'h0000, 16'h0001, 4'h7, 8'h00, 8'h00}};
    arc_exp = 1'b0;
    foreach (tbl[k]) begin
      {I_COMM_EN, I_FORCED_TRIP_PERMIT, I_REMOTE_ARC_REDUCTION_PERMIT, I_SETTINGS_PERMIT} = tbl[k].cfg;
      I_REPLY_DELAY_LONG = k[0];
      dly = k[0] ? LONG : SHORT;
      if (tbl[k].ev != 8'h00) exp_q.push_back(tbl[k].ev);
      if (tbl[k].ra == 16'h0001 && tbl[k].fc == 8'h06) arc_exp = 1'b1;
      u_master.send_frame(tbl[k].addr, tbl[k].ra, tbl[k].val);
      n = 0;
      while (O_TX_EN !== 1'b1 && n < 41 * BIT + dly) begin
        tick(1);
        n++;
      end
      if (tbl[k].fc == 8'h00) begin
        check(8'(n >= 41 * BIT + dly), 8'h01, "silence");
      end else begin
        check(8'(n >= 37 * BIT + dly && n < 41 * BIT + dly), 8'h01, "delay");
        u_master.get_byte(b);
        check(b, tbl[k].addr, "addr");
        u_master.get_byte(b);
        check(b, tbl[k].fc, "code");
      end
      tick(1);
      I_COMM_EN = 1'b0;
      tick(8);
      check(8'(O_ARC_ACTIVE), 8'(arc_exp), "rarc");
      check(8'(O_TRIP_SEL), 8'(sel), "kept");
    end
    check(8'(exp_q.size()), 8'h00, "left");
    finish_test();
  end
endmodule : tb
